/* rtl/dirq_core.sv */
// Interrupt control, bus cycle qualification and clock selection core.
`timescale 1ns/100ps
module dirq_core
  import dirq_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_chip_select_n,
  input wire logic i_read_strobe_n,
  input wire logic i_write_strobe_n,
  input wire logic [dirq_pkg::NUM_IRQ-1:0] i_event_set,
  input wire dirq_pkg::dirq_clr_t i_clr_req,
  input wire logic i_mask_we,
  input wire logic [dirq_pkg::NUM_IRQ-1:0] i_mask_wdata,
  input wire logic [4:0] i_op_irq_en,
  input wire logic i_ref_clock_in,
  input wire logic [3:0] i_ext_clk,
  input wire logic i_ct_load,
  input wire logic [15:0] i_ct_preset,
  input wire dirq_pkg::dirq_sel_t [dirq_pkg::NUM_SELECTORS-1:0] i_sel_cfg,
  output logic o_irq_out_n,
  output logic [dirq_pkg::NUM_IRQ-1:0] o_irq_status_reg,
  output logic [dirq_pkg::NUM_IRQ-1:0] o_irq_mask_reg,
  output logic [4:0] o_out_pins_3_to_7_n,
  output logic o_rd_access,
  output logic o_wr_access,
  output logic [dirq_pkg::NUM_SELECTORS-1:0] o_clk16_tick,
  output logic o_ct_out
);

  import dirq_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [7:0] pin_meta;
  logic [7:0] pin_sync;
  logic ref_last;
  logic [3:0] ext_last;
  logic ref_tick;
  logic [3:0] ext_tick;

  // Two flops on every pin from outside the clock domain.
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
    begin
      // Strobes rest high and timing inputs low, so no false edge follows reset.
      pin_meta <= 8'h07;
      pin_sync <= 8'h07;
    end
    else
    begin
      pin_meta <= {i_ext_clk, i_ref_clock_in, i_chip_select_n, i_read_strobe_n,
                   i_write_strobe_n};
      pin_sync <= pin_meta;
    end
  end

  // Edge history for the reference and external timing inputs.
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
    begin
      ref_last <= 1'b0;
      ext_last <= 4'h0;
    end
    else
    begin
      ref_last <= pin_sync[3];
      ext_last <= pin_sync[7:4];
    end
  end

  // Rising edges become one-cycle enable pulses.
  assign ref_tick = pin_sync[3] & ~ref_last;
  assign ext_tick = pin_sync[7:4] & ~ext_last;

  // ----------------------------------------------------------------
  // Bus cycle qualification
  // ----------------------------------------------------------------
  logic rd_active;
  logic wr_active;

  // Select and strobe are ORed low-true: the later assert starts, the first negate ends.
  // Bit 2 is the select, bit 1 the read strobe and bit 0 the write strobe.
  assign rd_active = ~pin_sync[2] & ~pin_sync[1];
  assign wr_active = ~pin_sync[2] & ~pin_sync[0];

  // Registered access levels.
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
    begin
      o_rd_access <= 1'b0;
      o_wr_access <= 1'b0;
    end
    else
    begin
      o_rd_access <= rd_active;
      o_wr_access <= wr_active;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt mask
  // ----------------------------------------------------------------
  // Mask write takes effect at once; a cleared bit drops its term next clock.
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
    begin
      o_irq_mask_reg <= IRQ_MASK_RESET;
    end
    else if (i_mask_we)
    begin
      o_irq_mask_reg <= i_mask_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------
  logic [NUM_IRQ-1:0] clr_vec;
  logic [NUM_IRQ-1:0] next_status;
  logic ct_event;

  // Map each clearing action to its source bit.
  always_comb
  begin
    clr_vec = 8'h00;
    clr_vec[IRQ_RXA_BIT] = i_clr_req.rd_rx_a;
    clr_vec[IRQ_RXB_BIT] = i_clr_req.rd_rx_b;
    clr_vec[IRQ_TXA_BIT] = i_clr_req.wr_tx_a;
    clr_vec[IRQ_TXB_BIT] = i_clr_req.wr_tx_b;
    clr_vec[IRQ_BRKA_BIT] = i_clr_req.cmd_brk_a;
    clr_vec[IRQ_BRKB_BIT] = i_clr_req.cmd_brk_b;
    clr_vec[IRQ_CT_BIT] = i_clr_req.cmd_ct_stop;
    clr_vec[IRQ_IPC_BIT] = i_clr_req.rd_ipc;
  end

  // A new event in the clearing cycle wins over the clear.
  assign next_status = (o_irq_status_reg & ~clr_vec) | i_event_set | {4'h0, ct_event, 3'h0};

  // Sticky status, visible whatever the mask holds.
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
    begin
      o_irq_status_reg <= IRQ_STATUS_RESET;
    end
    else
    begin
      o_irq_status_reg <= next_status;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt outputs
  // ----------------------------------------------------------------
  logic [NUM_IRQ-1:0] enabled;
  logic [4:0] discrete;

  // Masked terms from the next status, so the output follows within one clock.
  assign enabled = next_status & (i_mask_we ? i_mask_wdata : o_irq_mask_reg);

  // Discrete outputs: pin 3 counter/timer, 4 rx A, 5 rx B, 6 tx A, 7 tx B.
  assign discrete = {next_status[IRQ_TXB_BIT], next_status[IRQ_TXA_BIT],
                     next_status[IRQ_RXB_BIT], next_status[IRQ_RXA_BIT],
                     next_status[IRQ_CT_BIT]};

  // Single low-true interrupt and the optional discrete pins.
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
    begin
      o_irq_out_n <= 1'b1;
      o_out_pins_3_to_7_n <= 5'h1F;
    end
    else
    begin
      o_irq_out_n <= ~(|enabled);
      o_out_pins_3_to_7_n <= ~(discrete & i_op_irq_en);
    end
  end

  // ----------------------------------------------------------------
  // Counter/timer as a 16X divider
  // ----------------------------------------------------------------
  logic [15:0] ct_preset;
  logic [15:0] ct_cnt;
  logic ct_running;
  logic ct_tick;

  // Preset register and run control; stop command halts the count.
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
    begin
      ct_preset <= CT_PRESET_RESET;
      ct_running <= 1'b0; // The counter idles until the host first loads it.
    end
    else
    begin
      if (i_ct_load)
      begin
        ct_preset <= i_ct_preset;
        ct_running <= 1'b1;
      end
      else if (i_clr_req.cmd_ct_stop)
      begin
        ct_running <= 1'b0;
      end
    end
  end

  // Down count on reference ticks; square wave toggles at each reload, when the count reaches one.
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
    begin
      ct_cnt <= CT_PRESET_RESET;
      o_ct_out <= 1'b0;
    end
    else if (i_ct_load)
    begin
      ct_cnt <= i_ct_preset;
    end
    else if (ct_running && ref_tick)
    begin
      if (ct_cnt <= 16'h0001)
      begin
        ct_cnt <= ct_preset;
        o_ct_out <= ~o_ct_out;
      end
      else
      begin
        ct_cnt <= ct_cnt - 16'h0001;
      end
    end
  end

  // Counter event and 16X tick from the divider output.
  assign ct_tick = ct_running & ref_tick & (ct_cnt <= 16'h0001) & ~i_ct_load & ~o_ct_out;
  assign ct_event = ct_tick;

  // ----------------------------------------------------------------
  // Rate generator and clock selectors
  // ----------------------------------------------------------------
  logic [NUM_RATES-1:0] rate_tick;

  dirq_rate_gen u_rate_gen (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_ref_tick(ref_tick),
    .o_rate_tick(rate_tick)
  );

  // Each receiver and transmitter picks its own 16X source.
  genvar s;
  generate
    for (s = 0; s < NUM_SELECTORS; s++)
    begin : g_sel
      always_ff @(posedge i_clk_sys)
      begin
        if (!i_resetn)
        begin
          o_clk16_tick[s] <= 1'b0;
        end
        else
        begin
          unique case (i_sel_cfg[s].src)
            DIRQ_SRC_RATE: o_clk16_tick[s] <= (i_sel_cfg[s].rate < 5'(NUM_RATES)) ?
                                              rate_tick[i_sel_cfg[s].rate] : 1'b0;
            DIRQ_SRC_CT: o_clk16_tick[s] <= ct_tick;
            DIRQ_SRC_EXT: o_clk16_tick[s] <= ext_tick[s];
            default: o_clk16_tick[s] <= 1'b0;
          endcase
        end
      end
    end
  endgenerate

endmodule : dirq_core

/* rtl/dirq_pkg.sv */
// Package of constants and carrier types for the interrupt and baud timing core.
package dirq_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int SYS_CLK_HZ = 10000000;
  localparam int SYS_CLK_PERIOD_NS = 100;
  localparam int IRQ_NEGATE_MAX_NS = 300;
  localparam int IRQ_NEGATE_CYCLES = IRQ_NEGATE_MAX_NS / SYS_CLK_PERIOD_NS;
  // Standard rate table is exact for this reference frequency in Hz, save the 12'h417 and 12'h359 divisors.
  localparam int REF_NOMINAL_HZ = 3686400;

  // ----------------------------------------------------------------
  // Interrupt sources
  // ----------------------------------------------------------------
  localparam int NUM_IRQ = 8;
  localparam int IRQ_TXA_BIT = 0;
  localparam int IRQ_RXA_BIT = 1;
  localparam int IRQ_BRKA_BIT = 2;
  localparam int IRQ_CT_BIT = 3;
  localparam int IRQ_TXB_BIT = 4;
  localparam int IRQ_RXB_BIT = 5;
  localparam int IRQ_BRKB_BIT = 6;
  localparam int IRQ_IPC_BIT = 7;
  localparam logic [7:0] IRQ_MASK_RESET = 8'h00;
  localparam logic [7:0] IRQ_STATUS_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Rate generator
  // ----------------------------------------------------------------
  localparam int NUM_RATES = 23;
  localparam int RATE_SEL_W = 5;
  localparam int DIV_W = 12;
  localparam int NUM_SELECTORS = 4;
  localparam logic [15:0] CT_PRESET_RESET = 16'h0002;

  // Clock selector source codes.
  typedef enum logic [1:0] {
    DIRQ_SRC_RATE = 2'h0,
    DIRQ_SRC_CT = 2'h1,
    DIRQ_SRC_EXT = 2'h2
  } dirq_src_t;

  // Per-selector configuration: source and table index.
  typedef struct packed {
    dirq_src_t src;
    logic [RATE_SEL_W-1:0] rate;
  } dirq_sel_t;

  // Qualified host access strobes.
  typedef struct packed {
    logic rd_rx_a;
    logic rd_rx_b;
    logic wr_tx_a;
    logic wr_tx_b;
    logic cmd_brk_a;
    logic cmd_brk_b;
    logic cmd_ct_stop;
    logic rd_ipc;
  } dirq_clr_t;

endpackage : dirq_pkg

/* rtl/dirq_rate_gen.sv */
// Rate generator: 23 table rates as 16X enable pulses from the reference clock.
`timescale 1ns/100ps
module dirq_rate_gen
  import dirq_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_ref_tick,
  output logic [NUM_RATES-1:0] o_rate_tick
);

  // ----------------------------------------------------------------
  // Divider table
  // ----------------------------------------------------------------
  // Divisors of the reference giving 16X of 100 .. 230.4K baud; they scale with the reference.
  localparam logic [DIV_W-1:0] DIVS [NUM_RATES] = '{
    12'h900, 12'h600, 12'h417, 12'h359, 12'h300, 12'h180, 12'h0C0, 12'h080,
    12'h060, 12'h040, 12'h030, 12'h020, 12'h018, 12'h010, 12'h00C, 12'h008,
    12'h006, 12'h004, 12'h003, 12'h002, 12'h00A, 12'h005, 12'h001
  };

  // One counter per rate; each emits one pulse per divisor reference ticks.
  genvar g;
  generate
    for (g = 0; g < NUM_RATES; g++)
    begin : g_rate
      logic [DIV_W-1:0] cnt;
      always_ff @(posedge i_clk_sys)
      begin
        if (!i_resetn)
        begin
          cnt <= 12'h000;
          o_rate_tick[g] <= 1'b0;
        end
        else
        begin
          o_rate_tick[g] <= 1'b0;
          if (i_ref_tick)
          begin
            if (cnt >= DIVS[g] - 12'h001)
            begin
              cnt <= 12'h000;
              o_rate_tick[g] <= 1'b1;
            end
            else
            begin
              cnt <= cnt + 12'h001;
            end
          end
        end
      end
    end
  endgenerate

endmodule : dirq_rate_gen

/* verif/dirq_core_sva.sv */
// Assertion checker for the interrupt and baud timing core.
`timescale 1ns/100ps
module dirq_core_sva
  import dirq_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_chip_select_n,
  input wire logic i_read_strobe_n,
  input wire logic [dirq_pkg::NUM_IRQ-1:0] i_event_set,
  input wire dirq_pkg::dirq_clr_t i_clr_req,
  input wire logic i_mask_we,
  input wire logic [dirq_pkg::NUM_IRQ-1:0] i_mask_wdata,
  input wire logic o_irq_out_n,
  input wire logic [dirq_pkg::NUM_IRQ-1:0] o_irq_status_reg,
  input wire logic [dirq_pkg::NUM_IRQ-1:0] o_irq_mask_reg,
  input wire logic o_rd_access,
  input wire logic [4:0] i_op_irq_en,
  input wire logic [4:0] o_out_pins_3_to_7_n,
  input wire logic o_ct_out
);
  // All checks use the system clock and sleep while reset is low.
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  property p_irq_or;
    o_irq_out_n == ~|(o_irq_status_reg & o_irq_mask_reg);
  endproperty
  a_irq_or: assert property (p_irq_or) else $error("irq output wrong");
  property p_mask;
    i_mask_we |=> o_irq_mask_reg == $past(i_mask_wdata);
  endproperty
  a_mask: assert property (p_mask) else $error("mask not written");
  property p_set;
    |i_event_set |=> (o_irq_status_reg & $past(i_event_set)) == $past(i_event_set);
  endproperty
  a_set: assert property (p_set) else $error("status not set");
  property p_rx;
    i_clr_req.rd_rx_a && !i_event_set[IRQ_RXA_BIT] |=> !o_irq_status_reg[IRQ_RXA_BIT];
  endproperty
  a_rx: assert property (p_rx) else $error("rx not cleared");
  property p_tx;
    i_clr_req.wr_tx_b && !i_event_set[IRQ_TXB_BIT] |=> !o_irq_status_reg[IRQ_TXB_BIT];
  endproperty
  a_tx: assert property (p_tx) else $error("tx not cleared");
  property p_brk;
    i_clr_req.cmd_brk_a && !i_event_set[IRQ_BRKA_BIT] |=> !o_irq_status_reg[IRQ_BRKA_BIT];
  endproperty
  a_brk: assert property (p_brk) else $error("break not cleared");
  property p_ct;
    i_clr_req.cmd_ct_stop && !i_event_set[IRQ_CT_BIT] |=>
      !o_irq_status_reg[IRQ_CT_BIT] || $rose(o_ct_out);
  endproperty
  a_ct: assert property (p_ct) else $error("counter not cleared");
  property p_ipc;
    i_clr_req.rd_ipc && !i_event_set[IRQ_IPC_BIT] |=> !o_irq_status_reg[IRQ_IPC_BIT];
  endproperty
  a_ipc: assert property (p_ipc) else $error("change not cleared");
  property p_unmask;
    i_mask_we && i_mask_wdata == 8'h00 |-> ##[1:3] o_irq_out_n;
  endproperty
  a_unmask: assert property (p_unmask) else $error("irq stays low");
  property p_acc;
    (!i_chip_select_n && !i_read_strobe_n) [*4] |-> o_rd_access;
  endproperty
  a_acc: assert property (p_acc) else $error("read access missing");
  property p_pins;
    o_out_pins_3_to_7_n == ~({o_irq_status_reg[IRQ_TXB_BIT], o_irq_status_reg[IRQ_TXA_BIT],
      o_irq_status_reg[IRQ_RXB_BIT], o_irq_status_reg[IRQ_RXA_BIT],
      o_irq_status_reg[IRQ_CT_BIT]} & $past(i_op_irq_en));
  endproperty
  a_pins: assert property (p_pins) else $error("discrete pins wrong");
endmodule : dirq_core_sva
bind dirq_core dirq_core_sva u_sva (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
  .i_chip_select_n(i_chip_select_n), .i_read_strobe_n(i_read_strobe_n),
  .i_event_set(i_event_set), .i_clr_req(i_clr_req), .i_mask_we(i_mask_we),
  .i_mask_wdata(i_mask_wdata), .o_irq_out_n(o_irq_out_n),
  .o_irq_status_reg(o_irq_status_reg), .o_irq_mask_reg(o_irq_mask_reg),
  .o_rd_access(o_rd_access), .i_op_irq_en(i_op_irq_en),
  .o_out_pins_3_to_7_n(o_out_pins_3_to_7_n), .o_ct_out(o_ct_out));

/* verif/dirq_core_tb.sv */
// Self-checking testbench for the interrupt and baud timing core.
`timescale 1ns/100ps
module dirq_core_tb;
  import dirq_pkg::*;
  typedef struct {int kind; logic [7:0] exp;} dirq_note_t;
  localparam int CLR_OF[8] = '{5, 7, 3, 1, 4, 6, 2, 0};
  logic clk = 1'b0, rstn = 1'b0, go = 1'b0, rd = 1'b0, mwe = 1'b0, ref_clk = 1'b0, ld = 1'b0;
  logic [7:0] ev = 8'h00, mwd = 8'h00, clr = 8'h00, tsn = 8'h00, m, e;
  logic [4:0] open = 5'h00;
  logic [3:0] ext = 4'h0;
  dirq_sel_t [3:0] sel = '0;
  wire cs_n, rd_n, wr_n, busy, irq_n, rda, wra, ct_o;
  logic ct_d = 1'b0;
  wire [7:0] st, mk;
  wire [4:0] pins;
  wire [3:0] tick;
  int n_mismatch = 0, num_checks = 0, cnt[4], b0, b1, b2, b3, tg0, n_tog = 0;
  dirq_note_t q[$], nt;
  event chk_ev;
  dirq_core DUT (.i_clk_sys(clk), .i_resetn(rstn), .i_chip_select_n(cs_n),
    .i_read_strobe_n(rd_n), .i_write_strobe_n(wr_n), .i_event_set(ev),
    .i_clr_req(dirq_clr_t'(clr)), .i_mask_we(mwe), .i_mask_wdata(mwd), .i_op_irq_en(open),
    .i_ref_clock_in(ref_clk), .i_ext_clk(ext), .i_ct_load(ld), .i_ct_preset(16'h0004),
    .i_sel_cfg(sel), .o_irq_out_n(irq_n), .o_irq_status_reg(st), .o_irq_mask_reg(mk),
    .o_out_pins_3_to_7_n(pins), .o_rd_access(rda), .o_wr_access(wra), .o_clk16_tick(tick),
    .o_ct_out(ct_o));
  dirq_host_model HOST (.i_clk_sys(clk), .i_go(go), .i_rd(rd), .o_chip_select_n(cs_n),
    .o_read_strobe_n(rd_n), .o_write_strobe_n(wr_n), .o_busy(busy));
  // System clock, and a slower reference clock whose edges line up with its falling edges.
  initial forever #50 clk = ~clk;
  // Six system clocks per reference period; its edges meet system clock falling edges, never rising ones.
  initial forever #300 ref_clk = ~ref_clk;
  // Counts the 16X pulses of each selector and the toggles of the counter output.
  always @(posedge clk)
  begin
    for (int i = 0; i < 4; i++) cnt[i] <= cnt[i] + int'(tick[i]);
    n_tog <= n_tog + int'(ct_o !== ct_d);
    ct_d <= ct_o;
  end
  task automatic cmp8(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : cmp8
  task automatic cmp1(input string what, input logic seen, input logic exp);
    cmp8(what, {7'h0, seen}, {7'h0, exp});
  endtask : cmp1
  task automatic note(input int kind, input logic [7:0] exp);
    q.push_back('{kind, exp});
    -> chk_ev;
  endtask : note
  // Drives one set of pulses, then waits until outputs have settled.
  task automatic strobe(input logic [7:0] se, input logic [7:0] sc, input logic sm,
                        input logic [7:0] sw);
    @(posedge clk);
    ev <= se;
    clr <= sc;
    mwe <= sm;
    mwd <= sw;
    @(posedge clk);
    ev <= 8'h00;
    clr <= 8'h00;
    mwe <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask : strobe
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : print_verdict
  // Takes every queued expectation, oldest first, and compares it with the outputs.
  always @(chk_ev)
    while (q.size() > 0)
    begin
      nt = q.pop_front();
      case (nt.kind)
        0: cmp1("irq_out_n", irq_n, nt.exp[0]);
        1: cmp8("status", st, nt.exp);
        2: cmp8("mask", mk, nt.exp);
        3: cmp8("pins", {3'h0, pins}, nt.exp);
        4: cmp1("rd_access", rda, nt.exp[0]);
        5: cmp1("wr_access", wra, nt.exp[0]);
        default: cmp8("ticks", tsn, nt.exp);
      endcase
    end
  // Cuts a hung run short.
  initial
  begin
    #2000000;
    n_mismatch++;
    print_verdict();
  end
  // Main test sequence.
  initial
  begin
    void'($urandom(27103));
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    note(0, 8'h01);
    note(1, 8'h00);
    note(2, 8'h00);
    note(3, 8'h1F);
    $display("test reset done");
    for (int k = 0; k < 8; k++)
    begin
      strobe(8'h00, 8'h00, 1'b1, 8'h01 << k);
      strobe(8'h01 << k, 8'h00, 1'b0, 8'h00);
      note(1, 8'h01 << k);
      note(0, 8'h00);
      strobe(8'h00, 8'h00, 1'b1, 8'h00);
      note(0, 8'h01);
      strobe(8'h00, 8'h00, 1'b1, 8'h01 << k);
      note(0, 8'h00);
      strobe(8'h00, 8'h01 << CLR_OF[k], 1'b0, 8'h00);
      note(1, 8'h00);
      note(0, 8'h01);
    end
    $display("test sources done");
    repeat (20)
    begin
      m = 8'($urandom);
      e = 8'($urandom);
      @(posedge clk);
      open <= 5'($urandom);
      strobe(8'h00, 8'h00, 1'b1, m);
      strobe(e, 8'h00, 1'b0, 8'h00);
      note(2, m);
      note(1, e);
      note(0, {7'h0, ~|(e & m)});
      note(3, {3'h0, ~(open & {e[4], e[0], e[5], e[1], e[3]})});
      strobe(8'h00, 8'hFF, 1'b0, 8'h00);
      note(1, 8'h00);
    end
    $display("test random done");
    for (int r = 0; r < 2; r++)
    begin
      @(posedge clk);
      rd <= r[0];
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      repeat (6) @(posedge clk);
      @(negedge clk);
      note(4, {7'h0, r[0]});
      note(5, {7'h0, ~r[0]});
      repeat (8) @(posedge clk);
      @(negedge clk);
      note(4, 8'h00);
      note(5, 8'h00);
    end
    $display("test bus done");
    @(posedge clk);
    sel <= {4{DIRQ_SRC_CT, 5'h00}};
    ld <= 1'b1;
    @(posedge clk);
    ld <= 1'b0;
    b0 = cnt[0];
    tg0 = n_tog;
    repeat (60) @(posedge clk);
    @(negedge clk);
    // Preset 4: two output toggles and one 16X pulse within ten reference ticks.
    tsn = {4'(n_tog - tg0), 4'(cnt[0] - b0)};
    note(6, 8'h21);
    note(1, 8'h08);
    strobe(8'h00, 8'h02, 1'b0, 8'h00);
    note(1, 8'h00);
    sel <= {DIRQ_SRC_RATE, 5'h13, DIRQ_SRC_RATE, 5'h16, DIRQ_SRC_EXT, 5'h00,
            DIRQ_SRC_RATE, 5'h1F};
    @(posedge clk);
    @(negedge clk);
    b0 = cnt[1];
    b1 = cnt[0];
    b2 = cnt[2];
    b3 = cnt[3];
    for (int i = 0; i < 40; i++)
    begin
      @(posedge clk);
      ext <= {3'h0, i[2]} << 1;
    end
    repeat (8) @(posedge clk);
    @(negedge clk);
    tsn = {4'(cnt[1] - b0), 4'(cnt[0] - b1)};
    note(6, 8'h50);
    @(negedge clk);
    // Over 49 clocks, eight reference ticks: divide-by-one gives 8, divide-by-two 4.
    tsn = {4'(cnt[3] - b3), 4'(cnt[2] - b2)};
    note(6, 8'h48);
    $display("test timing done");
    @(negedge clk);
    print_verdict();
  end
endmodule : dirq_core_tb

/* verif/dirq_host_model.sv */
// Host bus model that makes one select and strobe access at a time.
`timescale 1ns/100ps
module dirq_host_model #(
  parameter int MIN_GAP = 2
) (
  input wire logic i_clk_sys,
  input wire logic i_go,
  input wire logic i_rd,
  output logic o_chip_select_n,
  output logic o_read_strobe_n,
  output logic o_write_strobe_n,
  output logic o_busy
);
  initial {o_chip_select_n, o_read_strobe_n, o_write_strobe_n, o_busy} = 4'hE;
  // Select leads the strobe and the strobe is released first.
  always @(posedge i_clk_sys)
  begin
    if (i_go && !o_busy)
    begin
      o_busy <= 1'b1;
      o_chip_select_n <= 1'b0;
      @(posedge i_clk_sys);
      o_read_strobe_n <= !i_rd;
      o_write_strobe_n <= i_rd;
      repeat (6) @(posedge i_clk_sys);
      {o_read_strobe_n, o_write_strobe_n} <= 2'h3;
      @(posedge i_clk_sys);
      o_chip_select_n <= 1'b1;
      repeat (MIN_GAP) @(posedge i_clk_sys);
      o_busy <= 1'b0;
    end
  end
endmodule : dirq_host_model
